// file: rtl/ptb_bridge.sv
// Host target to local bus bridge: window decode, real-time path, buffers,
// passive and active local sequencing.
// Assumes host_* come from logic on clk; lb_done and lb_rdata may be async.
`timescale 1ns/1ps
`include "ptb_regs.svh"
module ptb_bridge
	import ptb_pkg::*;
(
	// Clock and reset
	input  wire logic                              clk,
	input  wire logic                              rst_n,
	// Host target request, one data phase per cycle
	input  wire logic                              host_req,
	input  wire logic                              host_wr,
	input  wire logic                              host_io,
	input  wire logic                              host_burst,
	input  wire logic [31:0]                       host_addr,
	input  wire logic [3:0]                        host_be,
	input  wire logic [31:0]                       host_wdata,
	// Host answer, one cycle after the request
	output logic                                   host_ack,
	output logic                                   host_retry,
	output logic [31:0]                            host_rdata,
	// Configuration
	input  wire logic [`PTB_NUM_WIN-1:0]           cfg_win_en,
	input  wire logic [`PTB_NUM_WIN-1:0]           cfg_win_io,
	input  wire logic [`PTB_NUM_WIN-1:0][31:0]     cfg_win_base,
	input  wire logic [`PTB_NUM_WIN-1:0][31:0]     cfg_win_mask,
	input  wire logic [`PTB_NUM_WIN-1:0][1:0]      cfg_win_width,
	input  wire logic                              cfg_wf_en,
	input  wire logic                              cfg_rf_en,
	input  wire logic                              cfg_pf_en,
	input  wire logic                              cfg_active,
	input  wire logic [2:0]                        cfg_ws,
	// Local bus request
	output logic                                   lb_req,
	output logic                                   lb_strobe,
	output logic                                   lb_wr,
	output logic [31:0]                            lb_addr,
	output logic [3:0]                             lb_be,
	output logic [1:0]                             lb_win,
	output logic [1:0]                             lb_width,
	output logic                                   lb_burst,
	output logic [31:0]                            lb_wdata,
	// Local bus completion, possibly asynchronous
	input  wire logic                              lb_done,
	input  wire logic [31:0]                       lb_rdata,
	// Status
	output logic                                   wf_empty,
	output logic                                   rf_empty
);
	ptb_fifo_if #(.W($bits(ptb_job_s))) wf ();
	ptb_fifo_if #(.W(32))               rf ();

	ptb_fifo #(.W($bits(ptb_job_s)), .DEPTH(`PTB_FIFO_DEPTH)) u_wfifo (
		.clk   (clk),
		.rst_n (rst_n),
		.f     (wf.fifo)
	);
	ptb_fifo #(.W(32), .DEPTH(`PTB_FIFO_DEPTH)) u_rfifo (
		.clk   (clk),
		.rst_n (rst_n),
		.f     (rf.fifo)
	);

	// First match wins; mask never opens more than the largest window
	function automatic logic [2:0] win_decode(input logic [31:0] a, input logic io);
		logic [2:0] r;
		r = 3'h0;
		for (int i = `PTB_NUM_WIN - 1; i >= 0; i--) begin
			if (cfg_win_en[i] && cfg_win_io[i] == io &&
			    ((a ^ cfg_win_base[i]) & ~(cfg_win_mask[i] & `PTB_WIN_MAX_MASK)) == 32'h0)
				r = {1'b1, 2'(i)};
		end
		return r;
	endfunction : win_decode

	ptb_lb_e     state;
	ptb_rt_e     rt_st;
	ptb_src_e    src;
	ptb_job_s    job;
	logic        job_wr;
	logic [2:0]  ws_cnt;
	ptb_job_s    rt_job;
	logic        rt_wr;
	logic [31:0] rt_rdata;
	logic        pf_on;
	logic [31:0] pf_head;
	logic [31:0] pf_fetch;
	logic [1:0]  pf_win;
	logic        rf_sel;
	logic        done_m;
	logic        done_s;
	logic [31:0] rdata_m;
	logic [31:0] rdata_s;

	// Host side decode
	wire [2:0] dec      = win_decode(host_addr, host_io);
	wire       take     = host_req && dec[2];
	wire       wf_path  = take && host_wr && cfg_wf_en;
	wire       rf_path  = take && !host_wr && cfg_rf_en;
	wire       rt_path  = take && !wf_path && !rf_path;
	wire       wf_ok    = wf_path && !wf.full;
	wire       rt_match = rt_path && rt_st == RT_DONE && host_addr == rt_job.addr &&
	                      host_wr == rt_wr;
	wire       rt_start = rt_path && rt_st == RT_NONE;
	wire       pf_busy  = state != LB_IDLE && src == SRC_PF;
	wire       rf_hit   = rf_path && !rf.empty && host_addr == pf_head;
	wire       rf_rst   = rf_path && !rf_hit && !pf_busy;
	wire       ack      = wf_ok || rf_hit || rt_match;
	wire       retry    = take && !ack;

	// Local side sequencing
	wire       ws_end   = state == LB_WAIT && ws_cnt == `PTB_WS_ZERO;
	wire       pass_end = state == LB_PASS && done_s;
	wire       finish   = ws_end || pass_end;
	wire       pick_wf  = state == LB_IDLE && !wf.empty;
	wire       pick_rt  = state == LB_IDLE && wf.empty && rt_st == RT_PEND;
	wire       pick_pf  = state == LB_IDLE && wf.empty && rt_st != RT_PEND && pf_on &&
	                      !rf.full && !rf_rst;
	ptb_lb_e   next_state;

	always_comb begin
		case (state)
			LB_IDLE:  next_state = pick_wf ? LB_LOAD : (pick_rt || pick_pf) ? LB_START : LB_IDLE;
			LB_LOAD:  next_state = LB_START;
			LB_START: next_state = cfg_active ? LB_WAIT : LB_PASS;
			LB_WAIT:  next_state = ws_end ? LB_IDLE : LB_WAIT;
			LB_PASS:  next_state = pass_end ? LB_REL : LB_PASS;
			LB_REL:   next_state = done_s ? LB_REL : LB_IDLE;
			default:  next_state = LB_IDLE;
		endcase
	end

	assign wf.push  = wf_ok;
	assign wf.wdata = {host_addr, host_wdata, host_be, dec[1:0], host_burst};
	assign wf.pop   = pick_wf;
	assign wf.flush = 1'b0;
	assign rf.push  = finish && src == SRC_PF;
	assign rf.wdata = rdata_s;
	assign rf.pop   = rf_hit;
	assign rf.flush = rf_rst;

	// Request fields come from the job flops; lb_width is looked up in cfg_win_width by the job's window
	assign lb_req    = state == LB_WAIT || state == LB_PASS;
	assign lb_strobe = state == LB_WAIT;
	assign lb_wr     = job_wr;
	assign lb_addr   = job.addr;
	assign lb_be     = job.be;
	assign lb_win    = job.win;
	assign lb_width  = cfg_win_width[job.win];
	assign lb_burst  = job.burst;
	assign lb_wdata  = job.data;
	assign host_rdata = rf_sel ? rf.rdata : rt_rdata;
	assign wf_empty  = wf.empty;
	assign rf_empty  = rf.empty;

	// Completion crosses in from the user clock; data held stable by the request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			done_m  <= 1'b0;
			done_s  <= 1'b0;
			rdata_m <= '0;
			rdata_s <= '0;
		end else begin
			done_m  <= lb_done;
			done_s  <= done_m;
			rdata_m <= lb_rdata;
			rdata_s <= rdata_m;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			host_ack   <= 1'b0;
			host_retry <= 1'b0;
			rf_sel     <= 1'b0;
		end else begin
			host_ack   <= ack;
			host_retry <= retry;
			rf_sel     <= rf_hit;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state  <= LB_IDLE;
			src    <= SRC_WF;
			job    <= '0;
			job_wr <= 1'b0;
			ws_cnt <= `PTB_WS_ZERO;
		end else begin
			state <= next_state;
			if (pick_wf) begin
				src    <= SRC_WF;
				job_wr <= 1'b1;
			end else if (pick_rt) begin
				src    <= SRC_RT;
				job    <= rt_job;
				job_wr <= rt_wr;
			end else if (pick_pf) begin
				src    <= SRC_PF;
				job    <= '{addr: pf_fetch, data: 32'h0, be: 4'hf, win: pf_win, burst: cfg_pf_en};
				job_wr <= 1'b0;
			end
			if (state == LB_LOAD)
				job <= ptb_job_s'(wf.rdata);
			if (state == LB_START)
				ws_cnt <= cfg_ws;
			else if (state == LB_WAIT)
				ws_cnt <= ws_cnt - 1'b1;
		end
	end

	// Real-time transfer: hold the request until the host repeats it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rt_st    <= RT_NONE;
			rt_job   <= '0;
			rt_wr    <= 1'b0;
			rt_rdata <= '0;
		end else begin
			if (rt_start) begin
				rt_st  <= RT_PEND;
				rt_job <= '{addr: host_addr, data: host_wdata, be: host_be, win: dec[1:0],
				            burst: host_burst};
				rt_wr  <= host_wr;
			end else if (pick_rt)
				rt_st <= RT_BUSY;
			else if (finish && src == SRC_RT) begin
				rt_st    <= RT_DONE;
				rt_rdata <= rdata_s;
			end else if (rt_match)
				rt_st <= RT_NONE;
		end
	end

	// Prefetch: a restart flushes stale data; a single word when prefetch is off
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pf_on    <= 1'b0;
			pf_head  <= '0;
			pf_fetch <= '0;
			pf_win   <= 2'h0;
		end else if (rf_rst) begin
			pf_on    <= 1'b1;
			pf_head  <= host_addr;
			pf_fetch <= host_addr;
			pf_win   <= dec[1:0];
		end else begin
			if (rf_hit)
				pf_head <= pf_head + `PTB_WORD_STEP;
			if (finish && src == SRC_PF) begin
				pf_fetch <= pf_fetch + `PTB_WORD_STEP;
				if (!cfg_pf_en)
					pf_on <= 1'b0;
			end
		end
	end

	sequence s_req_held;
		lb_req && !done_s && !cfg_active;
	endsequence
	sequence s_strobe_start0;
		$rose(lb_strobe) && $past(cfg_ws) == `PTB_WS_ZERO;
	endsequence

	a_ack_or_retry: assert property (@(posedge clk) disable iff (!rst_n)
		!(host_ack && host_retry))
		else $error("ack and retry together");
	a_miss_silent: assert property (@(posedge clk) disable iff (!rst_n)
		host_req && !dec[2] |=> !host_ack && !host_retry)
		else $error("answer to an address outside every window");
	a_wbuf_zero_wait: assert property (@(posedge clk) disable iff (!rst_n)
		host_req && dec[2] && host_wr && cfg_wf_en && !wf.full |=> host_ack)
		else $error("buffered write not taken at once");
	a_rt_retry: assert property (@(posedge clk) disable iff (!rst_n)
		rt_path && rt_st != RT_DONE |=> host_retry)
		else $error("real-time access not retried while pending");
	a_rbuf_hit_ack: assert property (@(posedge clk) disable iff (!rst_n)
		rf_hit |=> host_ack && rf_sel)
		else $error("prefetched read not answered at once");
	a_req_holds: assert property (@(posedge clk) disable iff (!rst_n)
		s_req_held |=> lb_req && $stable(lb_addr) && $stable(lb_wr))
		else $error("local request dropped before completion");
	a_req_release: assert property (@(posedge clk) disable iff (!rst_n)
		lb_req && !cfg_active && done_s |=> !lb_req ##1 !lb_req)
		else $error("local request not released after completion");
	a_ws_zero: assert property (@(posedge clk) disable iff (!rst_n)
		s_strobe_start0 |=> !lb_strobe)
		else $error("zero wait-state strobe longer than one cycle");
	a_ws_bound: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(lb_strobe) |-> ##[1:8] !lb_strobe)
		else $error("active strobe longer than eight cycles");
endmodule : ptb_bridge

// file: rtl/ptb_regs.svh
// Constants for the host-to-local-bus bridge.
// Assumes inclusion by bare name from the package and the design modules.
// Functional notes
// - Bridge is host target only; every transfer starts with a host request.
// - Four windows, each decoded independently from host address space.
// - Each window is 8, 16 or 32 bits wide, memory or I/O, up to 512 MB.
// - Real-time path passes host reads and writes to the local bus unbuffered.
// - Request outputs show direction, byte lanes, window and burst flag.
// - Single data phases and bursts pass; buffered bursts run at full rate.
// - Host access is retried while the local side has not finished.
// - Two 32-byte buffers, one for host read data, one for host write data.
// - Enabled write buffer accepts host writes with no wait states.
// - Enabled read buffer may prefetch so host reads finish without waits.
// - Read and write buffers are enabled independently.
// - In active mode the sequencer strobes the bus with 0 to 7 wait states.
// - Local bus up to 40 MHz, user logic synchronous or asynchronous.
`ifndef PTB_REGS_SVH
`define PTB_REGS_SVH
`define PTB_NUM_WIN      4
`define PTB_WIN_MAX_MASK 32'h1fff_ffff
`define PTB_WORD_STEP    32'h0000_0004
`define PTB_FIFO_BYTES   32
`define PTB_FIFO_DEPTH   (`PTB_FIFO_BYTES / 4)
`define PTB_WS_ZERO      3'h0
`define PTB_WS_MAX       3'h7
`define PTB_LB_MAX_MHZ   40
`define PTB_WIDTH_8      2'h0
`define PTB_WIDTH_16     2'h1
`define PTB_WIDTH_32     2'h2
`endif

// file: rtl/ptb_pkg.sv
// Types shared by the bridge and its buffers.
// Assumes ptb_regs.svh is on the include path.
`include "ptb_regs.svh"
package ptb_pkg;
	typedef enum logic [2:0] {LB_IDLE, LB_LOAD, LB_START, LB_WAIT, LB_PASS, LB_REL} ptb_lb_e;
	typedef enum logic [1:0] {RT_NONE, RT_PEND, RT_BUSY, RT_DONE} ptb_rt_e;
	typedef enum logic [1:0] {SRC_WF, SRC_RT, SRC_PF} ptb_src_e;
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
		logic [3:0]  be;
		logic [1:0]  win;
		logic        burst;
	} ptb_job_s;
endpackage : ptb_pkg

// file: rtl/ptb_fifo_if.sv
// Signals between the bridge and one of its data buffers.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface ptb_fifo_if #(parameter int W = 32);
	logic         push;
	logic [W-1:0] wdata;
	logic         pop;
	logic         flush;
	logic [W-1:0] rdata;
	logic         full;
	logic         empty;
	modport fifo (input push, wdata, pop, flush, output rdata, full, empty);
	modport user (output push, wdata, pop, flush, input rdata, full, empty);
endinterface : ptb_fifo_if

// file: rtl/ptb_fifo.sv
// Small buffer memory; read data come from a register one cycle after pop.
// Assumes the user never pushes when full nor pops when empty.
`timescale 1ns/1ps
`include "ptb_regs.svh"
module ptb_fifo
	import ptb_pkg::*;
#(
	parameter int W     = 32,
	parameter int DEPTH = `PTB_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic    clk,
	input wire logic    rst_n,
	// Buffer port
	ptb_fifo_if.fifo    f
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wptr;
	logic [AW:0]  rptr;
	logic [W-1:0] rdata;
	wire          do_push = f.push && !f.full;
	wire          do_pop  = f.pop && !f.empty;

	assign f.empty = (wptr == rptr);
	assign f.full  = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
	assign f.rdata = rdata;

	always_ff @(posedge clk) begin
		if (do_push)
			mem[wptr[AW-1:0]] <= f.wdata;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wptr  <= '0;
			rptr  <= '0;
			rdata <= '0;
		end else if (f.flush) begin
			wptr <= '0;
			rptr <= '0;
		end else begin
			if (do_push)
				wptr <= wptr + 1'b1;
			if (do_pop) begin
				rptr  <= rptr + 1'b1;
				rdata <= mem[rptr[AW-1:0]];
			end
		end
	end

	// Flags stay honest: never both full and empty
	a_fifo_flags_sane: assert property (@(posedge clk) disable iff (!rst_n) !(f.full && f.empty))
		else $error("buffer full and empty together");
endmodule : ptb_fifo

// file: verif/ptb_lb_model.sv
// Passive user logic on the local bus: a 32-word memory that raises lb_done dly+1 cycles into a request.
// Assumes that in passive mode the bridge holds lb_req and its fields on clk until it sees lb_done.
`timescale 1ns/1ps
module ptb_lb_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Request from the bridge
	input  wire logic        lb_req,
	input  wire logic        lb_wr,
	input  wire logic [31:0] lb_addr,
	input  wire logic [31:0] lb_wdata,
	input  wire logic [3:0]  dly,
	// Completion
	output logic             lb_done,
	output logic [31:0]      lb_rdata
);
	logic [31:0] mem [0:31];
	logic [31:0] last;
	logic [3:0]  cnt;
	wire  [4:0]  idx = lb_addr[6:2];
	initial for (int i = 0; i < 32; i++) mem[i] = {16'hc0de, 16'(i)};
	// Released data line shows the inverse, so a stale capture cannot pass
	assign lb_rdata = lb_req ? mem[idx] : ~last;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lb_done <= 1'b0;
			cnt     <= 4'h0;
			last    <= 32'h0;
		end else if (lb_req !== 1'b1) begin
			lb_done <= 1'b0;
			cnt     <= 4'h0;
		end else begin
			last <= mem[idx];
			if (lb_wr)
				mem[idx] <= lb_wdata;
			if (cnt == dly)
				lb_done <= 1'b1;
			else
				cnt <= cnt + 4'h1;
		end
	end
endmodule : ptb_lb_model

// file: verif/tb_ptb_bridge.sv
// Self-checking bench for the bridge: host accesses through windows, buffers, active mode.
// Assumes ptb_lb_model answers the local side; all configuration is static per scenario.
`timescale 1ns/1ps
`include "ptb_regs.svh"
module tb_ptb_bridge;
	logic                               clk, rst_n, host_req, host_wr, host_io, host_burst;
	logic [31:0]                        host_addr, host_wdata, host_rdata, lb_addr;
	logic [31:0]                        lb_wdata, lb_rdata, rd;
	logic [31:0]                        cap_addr, cap_wdata;
	logic [3:0]                         host_be, lb_be, dly, cap_be, scnt, slen;
	logic                               host_ack, host_retry, lb_req, lb_strobe, lb_wr;
	logic                               lb_burst, lb_done, wf_empty, rf_empty, acked;
	logic                               cap_wr, cap_burst;
	logic [1:0]                         lb_win, lb_width, cap_win, cap_width;
	logic [`PTB_NUM_WIN-1:0]            cfg_win_en, cfg_win_io;
	logic [`PTB_NUM_WIN-1:0][31:0]      cfg_win_base, cfg_win_mask;
	logic [`PTB_NUM_WIN-1:0][1:0]       cfg_win_width;
	logic                               cfg_wf_en, cfg_rf_en, cfg_pf_en, cfg_active;
	logic [2:0]                         cfg_ws;
	logic [2:0]                         wsv [0:2];
	int                                 mismatches, checked, nret;

	ptb_bridge u_ptb_bridge (.clk, .rst_n, .host_req, .host_wr, .host_io, .host_burst,
		.host_addr, .host_be, .host_wdata, .host_ack, .host_retry, .host_rdata, .cfg_win_en,
		.cfg_win_io, .cfg_win_base, .cfg_win_mask, .cfg_win_width, .cfg_wf_en, .cfg_rf_en,
		.cfg_pf_en, .cfg_active, .cfg_ws, .lb_req, .lb_strobe, .lb_wr, .lb_addr, .lb_be,
		.lb_win, .lb_width, .lb_burst, .lb_wdata, .lb_done, .lb_rdata, .wf_empty, .rf_empty);
	ptb_lb_model u_ptb_lb_model (.clk, .rst_n, .lb_req, .lb_wr, .lb_addr, .lb_wdata, .dly,
		.lb_done, .lb_rdata);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Fields are stable while the request stands, so any cycle of it will do
	always @(posedge clk) if (lb_req === 1'b1) begin
		cap_win   <= lb_win;
		cap_be    <= lb_be;
		cap_wr    <= lb_wr;
		cap_burst <= lb_burst;
		cap_width <= lb_width;
		cap_addr  <= lb_addr;
		cap_wdata <= lb_wdata;
	end
	always @(posedge clk) begin
		if (!rst_n) begin
			scnt <= 4'h0;
			slen <= 4'h0;
		end else if (lb_strobe === 1'b1) begin
			scnt <= scnt + 4'h1;
		end else if (scnt != 4'h0) begin
			slen <= scnt;
			scnt <= 4'h0;
		end
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task finish_test;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test

	// One host phase, repeated while retried; a miss returns with acked low
	task automatic xfer(input logic wr, input logic io, input logic bu, input logic [31:0] a,
		input logic [31:0] d, input logic [3:0] be);
		acked = 1'b0;
		nret  = 0;
		for (int i = 0; i < 300; i++) begin
			@(posedge clk);
			{host_req, host_wr, host_io, host_burst} <= {1'b1, wr, io, bu};
			host_addr  <= a;
			host_be    <= be;
			host_wdata <= d;
			@(posedge clk);
			host_req <= 1'b0;
			#1;
			if (host_ack === 1'b1) begin
				acked = 1'b1;
				rd    = host_rdata;
				return;
			end
			if (host_retry !== 1'b1)
				return;
			nret++;
		end
		mismatches++;
		finish_test();
	endtask : xfer

	// Waits for the local side to stay quiet for 20 cycles
	task settle;
		int q;
		q = 0;
		for (int i = 0; i < 600 && q < 20; i++) begin
			@(posedge clk);
			q = (lb_req === 1'b1) ? 0 : q + 1;
		end
		if (q < 20) begin
			mismatches++;
			finish_test();
		end
	endtask : settle

	initial begin
		{rst_n, host_req, host_wr, host_io, host_burst} = 5'h0;
		{host_addr, host_wdata, host_be, dly} = 72'h0;
		{cfg_wf_en, cfg_rf_en, cfg_pf_en, cfg_active, cfg_ws} = 7'h0;
		cfg_win_en = 4'hf;
		cfg_win_io = 4'h2;
		wsv = '{3'h0, 3'h3, 3'h7};
		for (int w = 0; w < 4; w++) begin
			cfg_win_base[w]  = {4'(w + 1), 28'h0};
			cfg_win_mask[w]  = 32'h0000_0fff;
			cfg_win_width[w] = 2'(w % 3);
		end
		repeat (5) @(posedge clk);
		check(host_ack, 1'b0);
		check(host_retry, 1'b0);
		check(lb_req, 1'b0);
		check({wf_empty, rf_empty}, 2'h3);
		rst_n <= 1'b1;
		dly   <= 4'h6;
		xfer(1'b0, 1'b0, 1'b0, 32'hf000_0008, 32'h0, 4'hf);
		check(acked, 1'b0);
		xfer(1'b0, 1'b0, 1'b0, 32'h2000_0008, 32'h0, 4'hf);
		check(acked, 1'b0);
		// Open mask is cut to the largest window size
		cfg_win_mask[3] <= 32'hffff_ffff;
		xfer(1'b0, 1'b0, 1'b0, 32'h6000_0008, 32'h0, 4'hf);
		check(acked, 1'b0);
		xfer(1'b0, 1'b0, 1'b0, 32'h5fff_fff8, 32'h0, 4'hf);
		check(rd, {16'hc0de, 16'h1e});
		cfg_win_mask[3] <= 32'h0000_0fff;
		// Real-time path through each window in turn, slow local side
		for (int w = 0; w < 4; w++) begin
			xfer(1'b1, w == 1, w == 3, {4'(w + 1), 28'h8}, {24'h5500_00, 8'(w)}, 4'h1 << w);
			check(acked, 1'b1);
			check(nret != 0, 1'b1);
			check(cap_win, w);
			check(cap_be, 4'h1 << w);
			check(cap_wr, 1'b1);
			check(cap_burst, w == 3);
			check(cap_width, w % 3);
			check(cap_addr, {4'(w + 1), 28'h8});
			check(cap_wdata, {24'h5500_00, 8'(w)});
			xfer(1'b0, w == 1, 1'b0, {4'(w + 1), 28'h8}, 32'h0, 4'hf);
			check(rd, {24'h5500_00, 8'(w)});
			check(cap_wr, 1'b0);
		end
		check(slen, 4'h0);
		// Buffered burst: no waits even though the local side is slow
		dly       <= 4'h9;
		cfg_wf_en <= 1'b1;
		for (int k = 0; k < 5; k++) begin
			@(posedge clk);
			{host_req, host_wr, host_burst} <= {k < 4, 2'h3};
			host_addr  <= 32'h1000_0020 + 32'(4 * k);
			host_wdata <= 32'hb000_0000 + 32'(k);
			if (k > 0) begin
				#1;
				check({host_ack, host_retry}, 2'h2);
			end
		end
		check(wf_empty, 1'b0);
		settle();
		check(wf_empty, 1'b1);
		cfg_wf_en <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			xfer(1'b0, 1'b0, 1'b0, 32'h1000_0020 + 32'(4 * k), 32'h0, 4'hf);
			check(rd, 32'hb000_0000 + 32'(k));
		end
		// Read buffer with prefetch: first word retried, the rest without waits
		dly       <= 4'h2;
		cfg_rf_en <= 1'b1;
		cfg_pf_en <= 1'b1;
		xfer(1'b0, 1'b0, 1'b0, 32'h1000_0040, 32'h0, 4'hf);
		check(nret != 0, 1'b1);
		check(rd, {16'hc0de, 16'h10});
		settle();
		check(rf_empty, 1'b0);
		for (int k = 1; k < 8; k++) begin
			xfer(1'b0, 1'b0, 1'b0, 32'h1000_0040 + 32'(4 * k), 32'h0, 4'hf);
			check(nret, 0);
			check(rd, {16'hc0de, 16'(16 + k)});
		end
		// Prefetch off: a miss fetches exactly one word
		cfg_pf_en  <= 1'b0;
		settle();
		xfer(1'b0, 1'b0, 1'b0, 32'h1000_0070, 32'h0, 4'hf);
		check(nret != 0, 1'b1);
		check(rd, {16'hc0de, 16'h1c});
		check(rf_empty, 1'b1);
		cfg_rf_en  <= 1'b0;
		cfg_active <= 1'b1;
		// Active mode: strobe length follows the wait-state setting
		for (int k = 0; k < 3; k++) begin
			cfg_ws <= wsv[k];
			xfer(1'b1, 1'b0, 1'b0, 32'h1000_0060 + 32'(4 * k), 32'ha000_0000 + 32'(k), 4'hf);
			check(slen, wsv[k] + 4'h1);
		end
		xfer(1'b0, 1'b0, 1'b0, 32'h1000_0068, 32'h0, 4'hf);
		check(rd, 32'ha000_0002);
		check(slen, 4'h8);
		finish_test();
	end
endmodule : tb_ptb_bridge
